// *** rtl/rsalu_pkg.sv ***
/*
  Package for the rotate/subtract/skip execution datapath: operation codes,
  result carrier, flag layout and timing counts.
  Assumes a 20 MHz instruction clock and one operation request per cycle.
*/
package rsalu_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned BIT_SEL_W  = 3;
  localparam int unsigned MSB_POS    = 7;
  localparam int unsigned LSB_POS    = 0;
  localparam int unsigned NIB_HI_POS = 4;
  localparam int unsigned NIB_LO_TOP = 3;
  localparam logic [7:0]  BYTE_ONES  = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam int unsigned SKIP_CYCLES = 2;

  // Flag vector positions
  localparam int unsigned FLG_C  = 0;
  localparam int unsigned FLG_AC = 1;
  localparam int unsigned FLG_Z  = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned FLG_SC = 4;
  localparam int unsigned FLG_CZ = 5;
  localparam int unsigned FLG_W  = 6;
  localparam logic [5:0]  FLAGS_RST = 6'h00;
  localparam logic [7:0]  ACC_RST   = 8'h00;

  typedef enum logic [4:0] {
    OP_NONE                 = 5'h00,
    OP_ROT_LEFT_TO_ACC      = 5'h01,
    OP_ROT_LEFT_MEM         = 5'h02,
    OP_ROT_LEFT_CARRY_MEM   = 5'h03,
    OP_ROT_LEFT_CARRY_ACC   = 5'h04,
    OP_ROT_RIGHT_MEM        = 5'h05,
    OP_ROT_RIGHT_TO_ACC     = 5'h06,
    OP_ROT_RIGHT_CARRY_MEM  = 5'h07,
    OP_ROT_RIGHT_CARRY_ACC  = 5'h08,
    OP_SUB_BORROW_ACC       = 5'h09,
    OP_SUB_BORROW_IMM       = 5'h0A,
    OP_SUB_BORROW_TO_MEM    = 5'h0B,
    OP_SUB_ACC              = 5'h0C,
    OP_SUB_IMM              = 5'h0D,
    OP_MINUS_PLAIN_TO_MEM   = 5'h0E,
    OP_DEC_SKIP_ZERO        = 5'h0F,
    OP_DEC_SKIP_ZERO_ACC    = 5'h10,
    OP_INC_SKIP_ZERO        = 5'h11,
    OP_INC_SKIP_ZERO_ACC    = 5'h12,
    OP_SET_BYTE             = 5'h13,
    OP_SET_BIT              = 5'h14,
    OP_SKIP_NONZERO         = 5'h15,
    OP_SKIP_NONZERO_BIT     = 5'h16,
    OP_SWAP_NIBBLE          = 5'h17
  } rsalu_op_type;

  typedef struct packed {
    rsalu_op_type         op;
    logic [7:0]           mem_data;
    logic [7:0]           literal;
    logic [2:0]           bit_sel;
  } rsalu_req_type;

  typedef struct packed {
    logic                 mem_we;
    logic [7:0]           mem_data;
    logic                 skip;
  } rsalu_res_type;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_DUMMY = 2'b10
  } rsalu_state_type;

endpackage

// *** rtl/rsalu_core.sv ***
/*
  Rotate, subtract, set, swap and skip execution datapath with its own
  accumulator and flag register.
  Assumes the decoder presents one request per instruction cycle and may leave
  the next request up while o_busy is high (dummy cycle of a skip op); it is dropped.
*/
`timescale 1ns/1ps
module rsalu_core
  import rsalu_pkg::*;
(
  input  wire logic          i_mclk,
  input  wire logic          i_rstn,
  input  wire logic          i_valid,
  input  wire rsalu_req_type i_req,
  output logic               o_busy,
  output rsalu_res_type      o_res,
  output logic [7:0]         o_accumulator,
  output logic [5:0]         o_flags
);

  function automatic logic [7:0] rot_left(input logic [7:0] v, input logic in0);
    rot_left = {v[MSB_POS-1:LSB_POS], in0};
  endfunction

  function automatic logic [7:0] rot_right(input logic [7:0] v, input logic in7);
    rot_right = {in7, v[MSB_POS:LSB_POS+1]};
  endfunction

  logic [7:0]      acc_r;
  logic [7:0]      acc_nxt;
  logic [5:0]      flags_r;
  logic [5:0]      flags_nxt;
  rsalu_res_type   res_r;
  rsalu_res_type   res_nxt;
  rsalu_state_type state_r;
  rsalu_state_type state_nxt;

  wire logic       take    = i_valid && (state_r == ST_RUN);
  wire logic [7:0] m       = i_req.mem_data;
  wire logic       c_old   = flags_r[FLG_C];
  wire logic       is_imm  = (i_req.op == OP_SUB_BORROW_IMM) || (i_req.op == OP_SUB_IMM);
  wire logic [7:0] sub_rhs = is_imm ? i_req.literal : m;
  wire logic       use_brw = (i_req.op == OP_SUB_BORROW_ACC) ||
                             (i_req.op == OP_SUB_BORROW_IMM) ||
                             (i_req.op == OP_SUB_BORROW_TO_MEM);
  wire logic       borrow_in = use_brw & ~c_old;
  wire logic [8:0] diff    = {1'b0, acc_r} - {1'b0, sub_rhs} - {8'h00, borrow_in};
  wire logic [4:0] diff_lo = {1'b0, acc_r[3:0]} - {1'b0, sub_rhs[3:0]} - {4'h0, borrow_in};
  wire logic [7:0] sub_res = diff[7:0];
  wire logic       sub_c   = ~diff[8];
  wire logic       sub_ac  = ~diff_lo[4];
  wire logic       sub_ov  = (acc_r[MSB_POS] ^ sub_rhs[MSB_POS]) &
                             (acc_r[MSB_POS] ^ sub_res[MSB_POS]);
  wire logic       sub_z   = (sub_res == BYTE_ZERO);
  // Signed result sign: true sign even when the 8-bit result overflowed
  wire logic       sub_sc  = sub_res[MSB_POS] ^ sub_ov;
  // Zero over a multi-byte chain: only stays set if the previous zero held
  wire logic       sub_cz  = use_brw ? (sub_z & flags_r[FLG_Z]) : sub_z;
  wire logic [7:0] dec_res = m - BYTE_ONE;
  wire logic [7:0] inc_res = m + BYTE_ONE;
  wire logic [7:0] bit_msk = BYTE_ONE << i_req.bit_sel;
  wire logic [7:0] swp_res = {m[NIB_LO_TOP:LSB_POS], m[MSB_POS:NIB_HI_POS]};

  always_comb begin
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    res_nxt   = '0;
    state_nxt = ST_RUN;
    if (take) begin
      unique case (i_req.op)
        OP_ROT_LEFT_TO_ACC:     acc_nxt = rot_left(m, m[MSB_POS]);
        OP_ROT_LEFT_MEM: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = rot_left(m, m[MSB_POS]);
        end
        OP_ROT_LEFT_CARRY_MEM: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = rot_left(m, c_old);
          flags_nxt[FLG_C] = m[MSB_POS];
        end
        OP_ROT_LEFT_CARRY_ACC: begin
          acc_nxt          = rot_left(m, c_old);
          flags_nxt[FLG_C] = m[MSB_POS];
        end
        OP_ROT_RIGHT_MEM: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = rot_right(m, m[LSB_POS]);
        end
        OP_ROT_RIGHT_TO_ACC:    acc_nxt = rot_right(m, m[LSB_POS]);
        OP_ROT_RIGHT_CARRY_MEM: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = rot_right(m, c_old);
          flags_nxt[FLG_C] = m[LSB_POS];
        end
        OP_ROT_RIGHT_CARRY_ACC: begin
          acc_nxt          = rot_right(m, c_old);
          flags_nxt[FLG_C] = m[LSB_POS];
        end
        OP_SUB_BORROW_ACC, OP_SUB_BORROW_IMM, OP_SUB_ACC, OP_SUB_IMM: begin
          acc_nxt   = sub_res;
          flags_nxt = {sub_cz, sub_sc, sub_ov, sub_z, sub_ac, sub_c};
        end
        OP_SUB_BORROW_TO_MEM, OP_MINUS_PLAIN_TO_MEM: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = sub_res;
          flags_nxt = {sub_cz, sub_sc, sub_ov, sub_z, sub_ac, sub_c};
        end
        OP_DEC_SKIP_ZERO: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = dec_res;
          res_nxt.skip     = (dec_res == BYTE_ZERO);
          state_nxt        = ST_DUMMY;
        end
        OP_DEC_SKIP_ZERO_ACC: begin
          acc_nxt      = dec_res;
          res_nxt.skip = (dec_res == BYTE_ZERO);
          state_nxt    = ST_DUMMY;
        end
        OP_INC_SKIP_ZERO: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = inc_res;
          res_nxt.skip     = (inc_res == BYTE_ZERO);
          state_nxt        = ST_DUMMY;
        end
        OP_INC_SKIP_ZERO_ACC: begin
          acc_nxt      = inc_res;
          res_nxt.skip = (inc_res == BYTE_ZERO);
          state_nxt    = ST_DUMMY;
        end
        OP_SET_BYTE: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = BYTE_ONES;
        end
        OP_SET_BIT: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = m | bit_msk;
        end
        OP_SKIP_NONZERO: begin
          res_nxt.skip = (m != BYTE_ZERO);
          state_nxt    = ST_DUMMY;
        end
        OP_SKIP_NONZERO_BIT: begin
          res_nxt.skip = ((m & bit_msk) != BYTE_ZERO);
          state_nxt    = ST_DUMMY;
        end
        OP_SWAP_NIBBLE: begin
          res_nxt.mem_we   = 1'b1;
          res_nxt.mem_data = swp_res;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_r   <= ACC_RST;
      flags_r <= FLAGS_RST;
      res_r   <= '0;
      state_r <= ST_RUN;
    end else begin
      acc_r   <= acc_nxt;
      flags_r <= flags_nxt;
      res_r   <= res_nxt;
      state_r <= state_nxt;
    end
  end

  // Busy is the dummy state's one-hot bit, taken straight from its flop
  assign o_busy        = state_r[1];
  assign o_res         = res_r;
  assign o_accumulator = acc_r;
  assign o_flags       = flags_r;

  sequence s_skip_op;
    i_valid && !o_busy && (i_req.op inside {OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_ACC,
      OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_ACC, OP_SKIP_NONZERO, OP_SKIP_NONZERO_BIT});
  endsequence

  sequence s_dummy_then_free;
    o_busy ##1 !o_busy;
  endsequence

  // A request offered while busy must leave no trace
  sequence s_dummy_offer;
    o_busy && i_valid;
  endsequence

  AST_SKIP_TWO_CYCLES: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_skip_op |=> s_dummy_then_free)
    else $error("skip op did not take two cycles");

  AST_ROTL_ACC: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_ROT_LEFT_TO_ACC) |=>
      (o_accumulator == {$past(i_req.mem_data[6:0]), $past(i_req.mem_data[7])}) &&
      $stable(o_flags) && !o_res.mem_we)
    else $error("rotate left to accumulator wrong");

  AST_RLC_MEM: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_ROT_LEFT_CARRY_MEM) |=>
      o_res.mem_we && (o_res.mem_data[0] == $past(o_flags[FLG_C])) &&
      (o_flags[FLG_C] == $past(i_req.mem_data[7])) &&
      (o_flags[5:1] == $past(o_flags[5:1])))
    else $error("rotate left through carry to memory wrong");

  AST_RRC_ACC: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_ROT_RIGHT_CARRY_ACC) |=>
      (o_accumulator[7] == $past(o_flags[FLG_C])) &&
      (o_flags[FLG_C] == $past(i_req.mem_data[0])) && !o_res.mem_we)
    else $error("rotate right through carry to accumulator wrong");

  AST_RR_MEM: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_ROT_RIGHT_MEM) |=>
      o_res.mem_we && (o_res.mem_data == {$past(i_req.mem_data[0]),
      $past(i_req.mem_data[7:1])}) && $stable(o_flags))
    else $error("rotate right memory wrong");

  AST_SUB_CARRY: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SUB_ACC) |=>
      (o_flags[FLG_C] == ($past(o_accumulator) >= $past(i_req.mem_data))) &&
      (o_flags[FLG_Z] == (o_accumulator == 8'h00)))
    else $error("subtract carry or zero wrong");

  AST_DEC_SKIP: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_DEC_SKIP_ZERO && i_req.mem_data == 8'h01) |=>
      o_res.skip && o_res.mem_we && (o_res.mem_data == 8'h00) && $stable(o_flags))
    else $error("decrement skip on zero missing");

  AST_INC_ACC_SKIP: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_INC_SKIP_ZERO_ACC) |=>
      (o_accumulator == $past(i_req.mem_data) + 8'h01) &&
      (o_res.skip == (o_accumulator == 8'h00)) && !o_res.mem_we)
    else $error("increment to accumulator skip wrong");

  AST_SWAP: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SWAP_NIBBLE) |=>
      (o_res.mem_data == {$past(i_req.mem_data[3:0]), $past(i_req.mem_data[7:4])}) &&
      $stable(o_flags))
    else $error("nibble swap wrong");

  AST_ROTATE_LEFT_CARRY_TO_ACC_ACC: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_ROT_LEFT_CARRY_ACC) |=>
      (o_accumulator == {$past(i_req.mem_data[6:0]), $past(o_flags[FLG_C])}) &&
      (o_flags[FLG_C] == $past(i_req.mem_data[7])) && !o_res.mem_we)
    else $error("rotate left through carry to accumulator wrong");

  AST_RRA_ACC: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_ROT_RIGHT_TO_ACC) |=>
      (o_accumulator == {$past(i_req.mem_data[0]), $past(i_req.mem_data[7:1])}) &&
      $stable(o_flags) && !o_res.mem_we)
    else $error("rotate right to accumulator wrong");

  AST_RRC_MEM: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_ROT_RIGHT_CARRY_MEM) |=>
      o_res.mem_we && (o_flags[FLG_C] == $past(i_req.mem_data[0])) &&
      (o_res.mem_data == {$past(o_flags[FLG_C]), $past(i_req.mem_data[7:1])}) &&
      $stable(o_accumulator))
    else $error("rotate right through carry to memory wrong");

  // Borrow forms: the stored carry is a not-borrow, so it is inverted here
  AST_SBC_ACC: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SUB_BORROW_ACC) |=>
      (o_accumulator == $past(o_accumulator) - $past(i_req.mem_data) -
        {7'h00, !$past(o_flags[FLG_C])}) &&
      (o_flags[FLG_C] == ({1'b0, $past(o_accumulator)} >=
        ({1'b0, $past(i_req.mem_data)} + {8'h00, !$past(o_flags[FLG_C])}))))
    else $error("subtract with borrow to accumulator wrong");

  AST_SBC_IMM: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SUB_BORROW_IMM) |=>
      (o_accumulator == $past(o_accumulator) - $past(i_req.literal) -
        {7'h00, !$past(o_flags[FLG_C])}) && !o_res.mem_we)
    else $error("subtract literal with borrow wrong");

  AST_SUBTRACT_WITH_BORROW_TO_MEM_MEM: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SUB_BORROW_TO_MEM) |=>
      o_res.mem_we && $stable(o_accumulator) &&
      (o_res.mem_data == $past(o_accumulator) - $past(i_req.mem_data) -
        {7'h00, !$past(o_flags[FLG_C])}))
    else $error("subtract with borrow to memory wrong");

  AST_MINUS_PLAIN_TO_MEM_MEM: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_MINUS_PLAIN_TO_MEM) |=>
      o_res.mem_we && $stable(o_accumulator) &&
      (o_res.mem_data == $past(o_accumulator) - $past(i_req.mem_data)) &&
      (o_flags[FLG_C] == ($past(o_accumulator) >= $past(i_req.mem_data))) &&
      (o_flags[FLG_CZ] == o_flags[FLG_Z]))
    else $error("plain subtract to memory wrong");

  AST_SUB_OV_AC: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SUB_IMM) |=>
      (o_flags[FLG_OV] == (($past(o_accumulator[7]) != $past(i_req.literal[7])) &&
        (o_accumulator[7] != $past(o_accumulator[7])))) &&
      (o_flags[FLG_AC] == ($past(o_accumulator[3:0]) >= $past(i_req.literal[3:0]))))
    else $error("subtract overflow or nibble borrow wrong");

  AST_DEC_ACC: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_DEC_SKIP_ZERO_ACC) |=>
      (o_accumulator == $past(i_req.mem_data) - 8'h01) && !o_res.mem_we &&
      (o_res.skip == (o_accumulator == 8'h00)) && $stable(o_flags))
    else $error("decrement to accumulator skip wrong");

  AST_INC_MEM: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_INC_SKIP_ZERO) |=>
      o_res.mem_we && (o_res.mem_data == $past(i_req.mem_data) + 8'h01) &&
      (o_res.skip == (o_res.mem_data == 8'h00)) && $stable(o_flags) &&
      $stable(o_accumulator))
    else $error("increment memory skip wrong");

  AST_SET_BYTE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SET_BYTE) |=>
      o_res.mem_we && (o_res.mem_data == 8'hFF) && $stable(o_flags))
    else $error("byte set wrong");

  // Only the chosen bit may rise; every other bit must come back as it went in
  AST_SET_BIT: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SET_BIT) |=>
      o_res.mem_we && o_res.mem_data[$past(i_req.bit_sel)] && $stable(o_flags) &&
      ((o_res.mem_data & ~(8'h01 << $past(i_req.bit_sel))) ==
        ($past(i_req.mem_data) & ~(8'h01 << $past(i_req.bit_sel)))))
    else $error("bit set wrong");

  AST_SKIP_NZ: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SKIP_NONZERO) |=>
      (o_res.skip == ($past(i_req.mem_data) != 8'h00)) && !o_res.mem_we &&
      $stable(o_flags) && $stable(o_accumulator))
    else $error("skip if nonzero wrong");

  AST_SKIP_NZ_BIT: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && !o_busy && i_req.op == OP_SKIP_NONZERO_BIT) |=>
      (o_res.skip == $past(i_req.mem_data[i_req.bit_sel])) && !o_res.mem_we &&
      $stable(o_flags) && $stable(o_accumulator))
    else $error("skip if bit nonzero wrong");

  // The decoder may leave a request up through the dummy cycle; it must be ignored
  AST_DUMMY_REFUSED: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_dummy_offer |=> !o_busy && !o_res.mem_we && !o_res.skip &&
      $stable(o_accumulator) && $stable(o_flags))
    else $error("request taken during dummy cycle");

endmodule

// *** verification/tb_top.sv ***
/*
  Self-checking bench for the rotate, subtract, set, swap and skip datapath.
  Assumes rsalu_pkg and rsalu_core are compiled first; the core carries its
  own assertions, so no checker is bound here.
*/
`timescale 1ns/1ps
module tb_top
  import rsalu_pkg::*;
;
  logic          i_mclk;
  logic          i_rstn;
  logic          i_valid;
  rsalu_req_type i_req;
  logic          o_busy;
  rsalu_res_type o_res;
  logic [7:0]    o_accumulator;
  logic [5:0]    o_flags;
  int            num_errors;
  int            checks;
  logic [7:0]    m_acc;
  logic [5:0]    m_flg;

  rsalu_core i_rsalu_core (
    .i_mclk        (i_mclk),
    .i_rstn        (i_rstn),
    .i_valid       (i_valid),
    .i_req         (i_req),
    .o_busy        (o_busy),
    .o_res         (o_res),
    .o_accumulator (o_accumulator),
    .o_flags       (o_flags)
  );

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic close_out;
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Entered at a falling edge; keeps i_valid up so calls run back to back
  task automatic do_op(input rsalu_op_type op, input logic [7:0] m, input logic [7:0] lit,
                       input logic [2:0] b);
    logic [7:0] x, r;
    logic [8:0] d;
    logic [4:0] lo;
    logic       bin, brw, ov, we, skp, sk_cls;
    skp = 1'b0;
    r = m;
    we = op inside {OP_ROT_LEFT_MEM, OP_ROT_LEFT_CARRY_MEM, OP_ROT_RIGHT_MEM,
      OP_ROT_RIGHT_CARRY_MEM, OP_SUB_BORROW_TO_MEM, OP_MINUS_PLAIN_TO_MEM, OP_DEC_SKIP_ZERO,
      OP_INC_SKIP_ZERO, OP_SET_BYTE, OP_SET_BIT, OP_SWAP_NIBBLE};
    sk_cls = op inside {OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_ACC, OP_INC_SKIP_ZERO,
      OP_INC_SKIP_ZERO_ACC, OP_SKIP_NONZERO, OP_SKIP_NONZERO_BIT};
    case (op)
      OP_ROT_LEFT_TO_ACC, OP_ROT_LEFT_MEM: r = {m[6:0], m[7]};
      OP_ROT_LEFT_CARRY_MEM, OP_ROT_LEFT_CARRY_ACC: begin
        r = {m[6:0], m_flg[FLG_C]};
        m_flg[FLG_C] = m[7];
      end
      OP_ROT_RIGHT_MEM, OP_ROT_RIGHT_TO_ACC: r = {m[0], m[7:1]};
      OP_ROT_RIGHT_CARRY_MEM, OP_ROT_RIGHT_CARRY_ACC: begin
        r = {m_flg[FLG_C], m[7:1]};
        m_flg[FLG_C] = m[0];
      end
      OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_ACC: r = m - 8'h01;
      OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_ACC: r = m + 8'h01;
      OP_SET_BYTE: r = 8'hFF;
      OP_SET_BIT: r = m | (8'h01 << b);
      OP_SWAP_NIBBLE: r = {m[3:0], m[7:4]};
      OP_SKIP_NONZERO: skp = (m != 8'h00);
      OP_SKIP_NONZERO_BIT: skp = m[b];
      default: begin
        brw = op inside {OP_SUB_BORROW_ACC, OP_SUB_BORROW_IMM, OP_SUB_BORROW_TO_MEM};
        x = (op inside {OP_SUB_BORROW_IMM, OP_SUB_IMM}) ? lit : m;
        bin = brw & ~m_flg[FLG_C];
        d = {1'b0, m_acc} - {1'b0, x} - {8'h00, bin};
        lo = {1'b0, m_acc[3:0]} - {1'b0, x[3:0]} - {4'h0, bin};
        r = d[7:0];
        ov = (m_acc[7] ^ x[7]) & (r[7] ^ m_acc[7]);
        m_flg = {(r == 8'h00) & (~brw | m_flg[FLG_Z]), r[7] ^ ov, ov, r == 8'h00, ~lo[4], ~d[8]};
      end
    endcase
    if (op inside {OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_ACC, OP_INC_SKIP_ZERO,
        OP_INC_SKIP_ZERO_ACC}) begin
      skp = (r == 8'h00);
    end
    if (!we && !(op inside {OP_SKIP_NONZERO, OP_SKIP_NONZERO_BIT})) begin
      m_acc = r;
    end
    i_valid = 1'b1;
    i_req = '{op: op, mem_data: m, literal: lit, bit_sel: b};
    @(negedge i_mclk);
    cmp_bit("mem_we", we, o_res.mem_we);
    if (we) begin
      cmp_byte("mem_data", r, o_res.mem_data);
    end
    cmp_bit("skip", skp, o_res.skip);
    cmp_bit("busy", sk_cls, o_busy);
    cmp_byte("accumulator", m_acc, o_accumulator);
    cmp_byte("flags", {2'b00, m_flg}, {2'b00, o_flags});
    if (sk_cls) begin
      // Offered during the dummy cycle, so it must be dropped
      i_req.op = OP_SET_BYTE;
      @(negedge i_mclk);
      cmp_bit("dummy_we", 1'b0, o_res.mem_we);
      cmp_bit("busy_end", 1'b0, o_busy);
      cmp_byte("dummy_acc", m_acc, o_accumulator);
    end
  endtask

  task automatic idle;
    i_valid = 1'b0;
    @(negedge i_mclk);
  endtask

  task automatic chk_zero;
    cmp_byte("rst_acc", ACC_RST, o_accumulator);
    cmp_byte("rst_flags", {2'b00, FLAGS_RST}, {2'b00, o_flags});
    cmp_bit("rst_busy", 1'b0, o_busy);
    cmp_bit("rst_we", 1'b0, o_res.mem_we);
  endtask

  task automatic sc_rotate;
    rsalu_op_type ro [8] = '{OP_ROT_LEFT_TO_ACC, OP_ROT_LEFT_MEM, OP_ROT_LEFT_CARRY_MEM,
      OP_ROT_LEFT_CARRY_ACC, OP_ROT_RIGHT_MEM, OP_ROT_RIGHT_TO_ACC, OP_ROT_RIGHT_CARRY_MEM,
      OP_ROT_RIGHT_CARRY_ACC};
    // Nonzero flags first, so untouched flags are visible
    do_op(OP_SUB_IMM, 8'h00, 8'h80, 3'h0);
    for (int k = 0; k < 8; k++) begin
      do_op(ro[k], 8'h81, 8'h00, 3'h0);
      do_op(ro[k], 8'h4E, 8'h00, 3'h0);
    end
    idle();
  endtask

  task automatic sc_subtract;
    rsalu_op_type so [8] = '{OP_SUB_ACC, OP_SUB_BORROW_ACC, OP_SUB_BORROW_IMM, OP_SUB_IMM,
      OP_SUB_BORROW_TO_MEM, OP_MINUS_PLAIN_TO_MEM, OP_SUB_BORROW_IMM, OP_SUB_BORROW_TO_MEM};
    // Last step meets a clear carry, so the memory form really borrows
    logic [7:0]   sa [8] = '{8'h00, 8'h10, 8'h00, 8'h80, 8'h7F, 8'h55, 8'h2D, 8'h01};
    logic [7:0]   sx [8] = '{8'h01, 8'h0F, 8'h00, 8'h01, 8'hFF, 8'h55, 8'h3C, 8'h01};
    logic [7:0]   mv;
    for (int k = 0; k < 8; k++) begin
      mv = (so[k] inside {OP_SUB_BORROW_IMM, OP_SUB_IMM}) ? ~sx[k] : sx[k];
      // Accumulator loaded by a flag-neutral left rotate
      do_op(OP_ROT_LEFT_TO_ACC, {sa[k][0], sa[k][7:1]}, 8'h00, 3'h0);
      do_op(so[k], mv, ~mv, 3'h0);
    end
    idle();
  endtask

  task automatic sc_skip;
    rsalu_op_type so [8] = '{OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO,
      OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO_ACC, OP_DEC_SKIP_ZERO_ACC, OP_INC_SKIP_ZERO_ACC,
      OP_INC_SKIP_ZERO_ACC};
    logic [7:0]   sv [8] = '{8'h01, 8'h00, 8'hFF, 8'h7F, 8'h01, 8'h80, 8'hFF, 8'h00};
    for (int k = 0; k < 8; k++) begin
      do_op(so[k], sv[k], 8'h00, 3'h0);
    end
    idle();
  endtask

  task automatic sc_set_swap;
    do_op(OP_SET_BYTE, 8'h00, 8'h00, 3'h0);
    for (int k = 0; k < 8; k++) begin
      do_op(OP_SET_BIT, 8'h24, 8'h00, k[2:0]);
      do_op(OP_SKIP_NONZERO_BIT, 8'h01 << k, 8'h00, k[2:0]);
      do_op(OP_SKIP_NONZERO_BIT, ~(8'h01 << k), 8'h00, k[2:0]);
    end
    do_op(OP_SKIP_NONZERO, 8'h00, 8'h00, 3'h0);
    do_op(OP_SKIP_NONZERO, 8'h10, 8'h00, 3'h0);
    do_op(OP_SWAP_NIBBLE, 8'hA5, 8'h00, 3'h0);
    idle();
  endtask

  task automatic sc_mid_reset;
    i_rstn = 1'b0;
    @(negedge i_mclk);
    chk_zero();
    i_rstn = 1'b1;
    m_acc = ACC_RST;
    m_flg = FLAGS_RST;
    do_op(OP_ROT_RIGHT_TO_ACC, 8'h01, 8'h00, 3'h0);
    idle();
  endtask

  initial begin
    repeat (20000) @(posedge i_mclk);
    num_errors++;
    close_out();
  end

  initial begin
    num_errors = 0;
    checks = 0;
    i_rstn = 1'b0;
    i_valid = 1'b0;
    i_req = '0;
    m_acc = ACC_RST;
    m_flg = FLAGS_RST;
    repeat (6) @(negedge i_mclk);
    chk_zero();
    i_rstn = 1'b1;
    sc_rotate();
    sc_subtract();
    sc_skip();
    sc_set_swap();
    sc_mid_reset();
    close_out();
  end
endmodule
